//--- rtl/spi_consts.svh
// Constants shared by both ends of the serial control port
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// Clocking and timing
`define REF_CLK_HZ 125000000
`define POR_WAIT_S 2
`define WAIT_W 28
`define SCLK_MAX_HZ 40000000
`define SCLK_MIN_HALF ((`REF_CLK_HZ+2*`SCLK_MAX_HZ-1)/(2*`SCLK_MAX_HZ))
`define SCLK_SYNC_HALF 12
`define SCLK_HALF \
    ((`SCLK_MIN_HALF > `SCLK_SYNC_HALF) ? `SCLK_MIN_HALF : `SCLK_SYNC_HALF)
`define HALF_W 8

// Word sizes
`define ADDR_W 13
`define INSTR_BITS 16
`define BYTE_BITS 8
`define NUM_BUF 16
`define BUF_DEFAULT 8'h00

// Device register addresses
`define A_CFG0 13'h000
`define A_CFG1 13'h001
`define A_STATUS 13'h002
`define A_CHIP 13'h003
`define A_PID0 13'h004
`define A_PID1 13'h005
`define A_UPDATE 13'h00f
`define BUF_PAGE 9'h001

// Port configuration bits, pairs for config 0 only, mirrored except reset at 7 and 1
`define C0_RST_HI 7
`define C0_RST_LO 1
`define C0_LSB_HI 6
`define C0_LSB_LO 1
`define C0_ASC_HI 5
`define C0_ASC_LO 2
`define C0_4W_HI 4
`define C0_4W_LO 3
`define C1_RD_ACT 5
`define C1_CAL 2
`define UPD_BIT 0

// Device pin sampler indices
`define NUM_PIN_IN 5
`define IN_SCLK 0
`define IN_CSN 1
`define IN_SDI 2
`define IN_RSTN 3
`define IN_REF 4

// Host command port
`define H_CTRL 3'h0
`define H_MODE 3'h1
`define H_INSTR 3'h2
`define H_TX 3'h3
`define H_RX 3'h4
`define H_STATUS 3'h5
`define K_INSTR 0
`define K_WRITE 1
`define K_READ 2
`define K_END 3
`define K_EXTRA 4

`endif

//--- rtl/spi_pkg.sv
// Types for both ends of the serial control port
`include "spi_consts.svh"
package spi_pkg;

    typedef enum logic [1:0] {
        D_IDLE = 2'h0,
        D_INSTR = 2'h1,
        D_WRITE = 2'h3,
        D_READ = 2'h2
    } dev_phase_t;

    typedef struct packed {
        logic [`NUM_PIN_IN-1:0][2:0] sync;
        logic [`NUM_PIN_IN-1:0] filt;
        dev_phase_t phase;
        logic [3:0] bit_cnt;
        logic [`INSTR_BITS-1:0] sr;
        logic [`ADDR_W-1:0] addr;
        logic [`BYTE_BITS-1:0] out_sr;
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [`NUM_BUF-1:0][7:0] shadow;
        logic [`NUM_BUF-1:0][7:0] active;
        logic soft_rst;
        logic [`WAIT_W-1:0] wait_cnt;
        logic wait_done;
        logic cal_pulse;
        logic sdio_drv;
        logic sdio_oe;
        logic dout_drv;
        logic dout_oe;
    } dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_LOW = 2'h1,
        H_HIGH = 2'h3
    } host_phase_t;

    typedef struct packed {
        logic [1:0][2:0] sync;
        logic [1:0] filt;
        host_phase_t phase;
        logic [`HALF_W-1:0] cnt;
        logic [4:0] nbits;
        logic [`INSTR_BITS-1:0] sr;
        logic [`BYTE_BITS-1:0] rx;
        logic [`INSTR_BITS-1:0] instr;
        logic [`BYTE_BITS-1:0] tx;
        logic lsb;
        logic four;
        logic [15:0] rdata;
        logic sclk;
        logic cs_n;
        logic mo;
        logic mo_oe;
    } host_state_t;

endpackage

//--- rtl/spi_link_if.sv
// Serial link between host controller and device port
interface spi_link_if;
    logic sclk;
    logic cs_n;
    logic host_sdio_drv;
    logic host_sdio_oe;
    logic dev_sdio_drv;
    logic dev_sdio_oe;
    logic serial_data_out_pin_drv;
    logic serial_data_out_pin_oe;
    logic sdio;
    logic serial_data_out_pin;

    // Wire levels from the enables; undriven lines idle high like a pullup
    assign sdio = host_sdio_oe ? host_sdio_drv :
                  (dev_sdio_oe ? dev_sdio_drv : 1'b1);
    assign serial_data_out_pin = serial_data_out_pin_oe ?
                                 serial_data_out_pin_drv : 1'b1;

    modport host (
        output sclk, cs_n, host_sdio_drv, host_sdio_oe,
        input sdio, serial_data_out_pin
    );
    modport dev (
        input sclk, cs_n, sdio,
        output dev_sdio_drv, dev_sdio_oe,
        output serial_data_out_pin_drv, serial_data_out_pin_oe
    );
endinterface

//--- rtl/spi_port_device.sv
// Device end: serial control port, buffered registers and reset handling
`include "spi_consts.svh"
module spi_port_device #(
    parameter int unsigned POR_WAIT_CYCLES = `POR_WAIT_S * `REF_CLK_HZ,
    parameter logic [7:0] CHIP_TYPE = 8'h0a, // Arbitrary value
    parameter logic [15:0] PRODUCT_ID = 16'h0123 // Arbitrary value
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    spi_link_if.dev link,
    input wire logic hw_reset_n_in,
    input wire logic ref_present_in,
    output logic cal_start_out,
    output logic por_wait_done_out,
    output logic [`NUM_BUF*8-1:0] active_regs_out
);

    spi_pkg::dev_state_t q;
    spi_pkg::dev_state_t d;
    logic [`NUM_PIN_IN-1:0] pins;
    logic rise;
    logic fall;
    logic bit_in;
    logic lsb;
    logic four_wire;
    logic [`INSTR_BITS-1:0] nsr;
    logic [7:0] nbyte;
    logic [`ADDR_W-1:0] step;

    // Readback decode, shared by instruction end and byte end
    function automatic logic [7:0] read_reg(
        input spi_pkg::dev_state_t s,
        input logic [`ADDR_W-1:0] a
    );
        logic [7:0] v;
        v = 8'h00;
        if (a[`ADDR_W-1:4] == `BUF_PAGE) begin
            v = s.cfg1[`C1_RD_ACT] ? s.active[a[3:0]] : s.shadow[a[3:0]];
        end else begin
            case (a)
                `A_CFG0: v = s.cfg0;
                `A_CFG1: v = s.cfg1;
                `A_STATUS: v = {6'h00, s.cfg1[`C1_CAL], s.wait_done};
                `A_CHIP: v = CHIP_TYPE;
                `A_PID0: v = PRODUCT_ID[7:0];
                `A_PID1: v = PRODUCT_ID[15:8];
                default: v = 8'h00; // Unmapped and update read zero
            endcase
        end
        return v;
    endfunction

    assign pins = {ref_present_in, hw_reset_n_in, link.sdio, link.cs_n,
                   link.sclk};

    // Next-state logic for the whole port
    always_comb begin
        d = q;
        d.cal_pulse = 1'b0;
        // Three-stage samplers; a level counts once stages two and three agree
        for (int i = 0; i < `NUM_PIN_IN; i++) begin
            d.sync[i] = {q.sync[i][1:0], pins[i]};
            if (q.sync[i][1] == q.sync[i][2]) begin
                d.filt[i] = q.sync[i][2];
            end
        end
        rise = d.filt[`IN_SCLK] & ~q.filt[`IN_SCLK];
        fall = ~d.filt[`IN_SCLK] & q.filt[`IN_SCLK];
        bit_in = d.filt[`IN_SDI];
        lsb = q.cfg0[`C0_LSB_HI] & q.cfg0[`C0_LSB_LO];
        four_wire = q.cfg0[`C0_4W_HI] & q.cfg0[`C0_4W_LO];
        nsr = lsb ? {bit_in, q.sr[`INSTR_BITS-1:1]}
                  : {q.sr[`INSTR_BITS-2:0], bit_in};
        nbyte = lsb ? {bit_in, q.sr[7:1]} : {q.sr[6:0], bit_in};
        // Ascending only when both mirrored bits are set
        if (q.cfg0[`C0_ASC_HI] & q.cfg0[`C0_ASC_LO]) begin
            step = q.addr + 13'h0001;
        end else begin
            step = q.addr - 13'h0001;
        end

        // Power-on wait; restarts only on reset_in, not on the reset pin
        if (!q.wait_done) begin
            d.wait_cnt = q.wait_cnt + 28'h0000001;
            if (q.wait_cnt == `WAIT_W'(POR_WAIT_CYCLES - 1)) begin
                d.wait_done = 1'b1;
            end
        end
        // Pending calibration fires once the wait ends and reference is up
        if (q.cfg1[`C1_CAL] & q.wait_done & q.filt[`IN_REF]) begin
            d.cal_pulse = 1'b1;
            d.cfg1[`C1_CAL] = 1'b0;
        end

        if (d.filt[`IN_CSN]) begin
            // Select high: drop partial bits and release the pins
            d.phase = spi_pkg::D_IDLE;
            d.sdio_oe = 1'b0;
            d.dout_oe = 1'b0;
        end else begin
            unique case (q.phase)
                spi_pkg::D_IDLE: begin
                    d.phase = spi_pkg::D_INSTR;
                    d.bit_cnt = 4'h0;
                end
                spi_pkg::D_INSTR: begin
                    // Always sixteen bits, no short instruction form
                    if (rise) begin
                        d.sr = nsr;
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'(`INSTR_BITS - 1)) begin
                            d.bit_cnt = 4'h0;
                            // Instruction bits 14 and 13 are dropped; the address is the low 13 bits
                            d.addr = nsr[`ADDR_W-1:0];
                            if (nsr[`INSTR_BITS-1]) begin
                                d.phase = spi_pkg::D_READ;
                                d.out_sr = read_reg(q, nsr[`ADDR_W-1:0]);
                            end else begin
                                d.phase = spi_pkg::D_WRITE;
                            end
                        end
                    end
                end
                spi_pkg::D_WRITE: begin
                    if (rise) begin
                        d.sr = {q.sr[`INSTR_BITS-1:8], nbyte};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'(`BYTE_BITS - 1)) begin
                            d.bit_cnt = 4'h0;
                            d.addr = step;
                            if (q.addr[`ADDR_W-1:4] == `BUF_PAGE) begin
                                d.shadow[q.addr[3:0]] = nbyte;
                            end else begin
                                case (q.addr)
                                    `A_CFG0: begin
                                        d.cfg0 = nbyte;
                                        if (nbyte[`C0_RST_HI]
                                            & nbyte[`C0_RST_LO]) begin
                                            d.soft_rst = 1'b1;
                                        end
                                    end
                                    `A_CFG1: d.cfg1 = nbyte;
                                    `A_UPDATE: begin
                                        if (nbyte[`UPD_BIT]) begin
                                            d.active = q.shadow;
                                        end
                                    end
                                    default: ; // Read-only or unmapped
                                endcase
                            end
                        end
                    end
                end
                spi_pkg::D_READ: begin
                    // Launch on the falling edge, host takes it on the rise
                    if (fall) begin
                        d.sdio_drv = lsb ? q.out_sr[0] : q.out_sr[7];
                        d.dout_drv = lsb ? q.out_sr[0] : q.out_sr[7];
                        d.out_sr = lsb ? {1'b0, q.out_sr[7:1]}
                                       : {q.out_sr[6:0], 1'b0};
                        d.sdio_oe = ~four_wire;
                        d.dout_oe = four_wire;
                    end
                    if (rise) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'(`BYTE_BITS - 1)) begin
                            d.bit_cnt = 4'h0;
                            d.addr = step;
                            d.out_sr = read_reg(q, step);
                        end
                    end
                end
            endcase
        end

        // Soft reset completes on one more serial clock rise
        if (q.soft_rst & rise) begin
            d.soft_rst = 1'b0;
            d.cfg0[`C0_RST_HI] = 1'b0;
            d.cfg1[`C1_CAL] = 1'b0;
        end
        // Buffered and active copies held at default during soft reset
        if (d.soft_rst) begin
            d.shadow = {`NUM_BUF{`BUF_DEFAULT}};
            d.active = {`NUM_BUF{`BUF_DEFAULT}};
        end
        // Reset pin low holds every register at default except the status wait bit
        if (!d.filt[`IN_RSTN]) begin
            d.cfg0 = 8'h00;
            d.cfg1 = 8'h00;
            d.shadow = {`NUM_BUF{`BUF_DEFAULT}};
            d.active = {`NUM_BUF{`BUF_DEFAULT}};
            d.soft_rst = 1'b0;
            d.phase = spi_pkg::D_IDLE;
            d.sdio_oe = 1'b0;
            d.dout_oe = 1'b0;
        end
    end

    // State register; filtered select starts high so no frame is seen
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            q <= '0;
            // Select and reset pin samplers start high, their idle level, or a false frame follows
            q.sync[`IN_CSN] <= '1;
            q.sync[`IN_RSTN] <= '1;
            q.filt[`IN_CSN] <= 1'b1;
            q.filt[`IN_RSTN] <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.dev_sdio_drv = q.sdio_drv;
    assign link.dev_sdio_oe = q.sdio_oe;
    assign link.serial_data_out_pin_drv = q.dout_drv;
    assign link.serial_data_out_pin_oe = q.dout_oe;
    assign cal_start_out = q.cal_pulse;
    assign por_wait_done_out = q.wait_done;
    assign active_regs_out = q.active;

endmodule

//--- rtl/spi_port_host.sv
// Host end: serial clock maker and shifter driven by a register port
`include "spi_consts.svh"
module spi_port_host (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    spi_link_if.host link,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic busy_out
);

    spi_pkg::host_state_t q;
    spi_pkg::host_state_t d;
    logic [1:0] pins;
    logic busy;
    logic start;
    logic drive;
    logic rx_bit;
    logic [`INSTR_BITS-1:0] sr_new;
    logic [`INSTR_BITS-1:0] sr_sh;

    assign pins = {link.serial_data_out_pin, link.sdio};

    // Next-state logic
    always_comb begin
        d = q;
        d.rdata = 16'h0000;
        start = 1'b0;
        drive = 1'b0;
        sr_new = q.sr;
        for (int i = 0; i < 2; i++) begin
            d.sync[i] = {q.sync[i][1:0], pins[i]};
            if (q.sync[i][1] == q.sync[i][2]) begin
                d.filt[i] = q.sync[i][2];
            end
        end
        rx_bit = q.four ? d.filt[1] : d.filt[0];
        busy = q.phase != spi_pkg::H_IDLE;
        sr_sh = q.lsb ? {1'b0, q.sr[`INSTR_BITS-1:1]}
                      : {q.sr[`INSTR_BITS-2:0], 1'b0};

        // Commands; control writes ignored while a segment is shifting
        if (wr_in) begin
            case (addr_in)
                `H_CTRL: begin
                    if (!busy) begin
                        if (wdata_in[`K_INSTR]) begin
                            d.cs_n = 1'b0;
                            sr_new = q.instr;
                            d.nbits = 5'(`INSTR_BITS);
                            drive = 1'b1;
                            start = 1'b1;
                        end else if (wdata_in[`K_WRITE]) begin
                            sr_new = q.lsb ? {8'h00, q.tx} : {q.tx, 8'h00};
                            d.nbits = 5'(`BYTE_BITS);
                            drive = 1'b1;
                            start = 1'b1;
                        end else if (wdata_in[`K_READ]) begin
                            d.nbits = 5'(`BYTE_BITS);
                            start = 1'b1;
                        end else if (wdata_in[`K_END]) begin
                            d.cs_n = 1'b1;
                        end else if (wdata_in[`K_EXTRA]) begin
                            d.nbits = 5'h01;
                            start = 1'b1;
                        end
                    end
                end
                `H_MODE: begin
                    d.lsb = wdata_in[0];
                    d.four = wdata_in[1];
                end
                `H_INSTR: d.instr = wdata_in;
                `H_TX: d.tx = wdata_in[7:0];
                default: ;
            endcase
        end
        if (start) begin
            d.sr = sr_new;
            d.phase = spi_pkg::H_LOW;
            d.cnt = `HALF_W'(0);
            d.mo_oe = drive;
            d.mo = q.lsb ? sr_new[0] : sr_new[`INSTR_BITS-1];
        end

        // Clock generation; half period keeps at or below the top rate
        unique case (q.phase)
            spi_pkg::H_IDLE: ;
            spi_pkg::H_LOW: begin
                d.cnt = q.cnt + `HALF_W'(1);
                if (q.cnt == `HALF_W'(`SCLK_HALF - 1)) begin
                    d.cnt = `HALF_W'(0);
                    d.sclk = 1'b1;
                    d.phase = spi_pkg::H_HIGH;
                    // Read bit taken on the rising edge
                    d.rx = q.lsb ? {rx_bit, q.rx[7:1]}
                                 : {q.rx[6:0], rx_bit};
                end
            end
            spi_pkg::H_HIGH: begin
                d.cnt = q.cnt + `HALF_W'(1);
                if (q.cnt == `HALF_W'(`SCLK_HALF - 1)) begin
                    d.cnt = `HALF_W'(0);
                    d.sclk = 1'b0;
                    d.sr = sr_sh;
                    d.mo = q.lsb ? sr_sh[0] : sr_sh[`INSTR_BITS-1];
                    d.nbits = q.nbits - 5'h01;
                    if (q.nbits == 5'h01) begin
                        d.phase = spi_pkg::H_IDLE;
                        d.mo_oe = 1'b0; // Free the line for a read
                    end else begin
                        d.phase = spi_pkg::H_LOW;
                    end
                end
            end
            default: d.phase = spi_pkg::H_IDLE;
        endcase

        // Read data stands only in the cycle after the strobe
        if (rd_in) begin
            case (addr_in)
                `H_MODE: d.rdata = {14'h0000, q.four, q.lsb};
                `H_INSTR: d.rdata = q.instr;
                `H_TX: d.rdata = {8'h00, q.tx};
                `H_RX: d.rdata = {8'h00, q.rx};
                `H_STATUS: d.rdata = {14'h0000, ~q.cs_n, busy};
                default: d.rdata = 16'h0000;
            endcase
        end
    end

    // State register; select idles high
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            q <= '0;
            q.cs_n <= 1'b1;
            // Data samplers start at the pullup level
            q.sync <= '1;
            q.filt <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.host_sdio_drv = q.mo;
    assign link.host_sdio_oe = q.mo_oe;
    assign rdata_out = q.rdata;
    assign busy_out = q.phase != spi_pkg::H_IDLE;

endmodule

//--- tb/spi_link_props.sv
// Wire checks on the serial link between host and device ends
module spi_link_props (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_sdio_drv,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_drv,
    input wire logic dev_sdio_oe,
    input wire logic serial_data_out_pin_drv,
    input wire logic serial_data_out_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rise_q;
    logic sclk_q;

    // Rising link clock edges since select fell, saturating
    always_ff @(posedge ref_clk_in) begin
        sclk_q <= reset_in ? 1'b0 : sclk;
        if (reset_in || cs_n) begin
            rise_q <= 8'h00;
        end else if (sclk && !sclk_q && rise_q != 8'hff) begin
            rise_q <= rise_q + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    chk_idle_release: assert property (
        cs_n [*5] |-> !dev_sdio_oe && !serial_data_out_pin_oe)
        else $error("data pin driven while deselected");
    chk_one_out_pin: assert property (
        !(dev_sdio_oe && serial_data_out_pin_oe))
        else $error("both device data pins driven");
    chk_no_contend: assert property (
        !(host_sdio_oe && dev_sdio_oe))
        else $error("shared data pin driven by both ends");
    chk_instr_quiet: assert property (
        !cs_n && rise_q < 8'h10 |->
        !dev_sdio_oe && !serial_data_out_pin_oe)
        else $error("device drove data inside instruction");
    chk_launch_low: assert property (
        $rose(dev_sdio_oe) || $rose(serial_data_out_pin_oe) |-> !sclk)
        else $error("read data launched while clock high");
    chk_dev_hold: assert property (
        sclk |-> $stable(dev_sdio_drv) && $stable(serial_data_out_pin_drv))
        else $error("device data moved while clock high");
    chk_host_hold: assert property (
        sclk |-> $stable(host_sdio_drv))
        else $error("host data moved while clock high");
    chk_clock_high: assert property (
        $rose(sclk) |=> sclk [*8])
        else $error("link clock high phase too short");
    chk_select_setup: assert property (
        $fell(cs_n) |-> !sclk [*8])
        else $error("clock rose too soon after select");
    chk_whole_units: assert property (
        $rose(cs_n) |-> rise_q >= 8'h10 && rise_q[2:0] == 3'h0)
        else $error("frame ended inside a unit");
endmodule

//--- tb/serial_control_port_reset_tb.sv
// Bench driving the host register port against the device end
`include "spi_consts.svh"
module serial_control_port_reset_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CHIP = 8'h3c; // Arbitrary value
    localparam logic [15:0] PID = 16'h5a17; // Arbitrary value
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic hw_reset_n = 1'b1;
    logic ref_ok = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [15:0] rdata;
    logic busy;
    logic cal;
    logic wait_done;
    logic [127:0] act;
    int n_errors = 0;
    int n_compared = 0;
    int n_cal = 0;

    spi_link_if spi_link_if_i ();
    spi_port_device #(
        .POR_WAIT_CYCLES(2000),
        .CHIP_TYPE(CHIP),
        .PRODUCT_ID(PID)
    ) spi_port_device_i (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .link(spi_link_if_i),
        .hw_reset_n_in(hw_reset_n),
        .ref_present_in(ref_ok),
        .cal_start_out(cal),
        .por_wait_done_out(wait_done),
        .active_regs_out(act)
    );
    spi_port_host spi_port_host_i (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .link(spi_link_if_i),
        .addr_in(addr),
        .wdata_in(wdata),
        .wr_in(wr_s),
        .rd_in(rd_s),
        .rdata_out(rdata),
        .busy_out(busy)
    );
    spi_link_props spi_link_props_i (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .sclk(spi_link_if_i.sclk),
        .cs_n(spi_link_if_i.cs_n),
        .host_sdio_drv(spi_link_if_i.host_sdio_drv),
        .host_sdio_oe(spi_link_if_i.host_sdio_oe),
        .dev_sdio_drv(spi_link_if_i.dev_sdio_drv),
        .dev_sdio_oe(spi_link_if_i.dev_sdio_oe),
        .serial_data_out_pin_drv(spi_link_if_i.serial_data_out_pin_drv),
        .serial_data_out_pin_oe(spi_link_if_i.serial_data_out_pin_oe)
    );

    initial begin
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One strobe cycle, then an idle edge so strobes never collide
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk_in);
        wr_s <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_in);
        rd_s <= 1'b0;
        #1;
        check("rdata", e, rdata);
        @(posedge ref_clk_in);
    endtask

    // Command, then wait for the segment to finish shifting
    task automatic cmd(input logic [15:0] c);
        wr(`H_CTRL, c);
        repeat (1000) begin
            #1;
            if (busy === 1'b0) break;
            @(posedge ref_clk_in);
        end
        check("busy", 0, busy);
    endtask

    // Whole frame: instruction, n bytes from d low byte first, end
    task automatic xfer(input logic rw, input logic [12:0] a,
                        input int n, input logic [31:0] d);
        wr(`H_INSTR, {rw, 2'b00, a});
        cmd(16'h0001);
        rd(`H_STATUS, 16'h0002);
        for (int i = 0; i < n; i++) begin
            if (rw) begin
                cmd(16'h0004);
                rd(`H_RX, {8'h00, d[8*i+:8]});
            end else begin
                wr(`H_TX, {8'h00, d[8*i+:8]});
                cmd(16'h0002);
            end
        end
        cmd(16'h0008);
    endtask

    // Calibration may start only after the wait and with a reference;
    // looked at mid-cycle so the one-cycle pulse is seen exactly once
    always @(negedge ref_clk_in) begin
        if (cal === 1'b1) begin
            n_cal++;
            check("cal gate", 1, wait_done & ref_ok);
        end
    end

    initial begin
        // Roughly three times the expected run length
        #400us;
        n_errors++;
        finish_test;
    end

    initial begin
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        rd(3'h7, 16'h0000);
        xfer(1'b0, `A_CFG1, 1, 32'h04);
        check("wait", 0, wait_done);
        repeat (3000) begin
            if (wait_done === 1'b1) break;
            @(posedge ref_clk_in);
        end
        check("wait done", 1, wait_done);
        repeat (30) @(posedge ref_clk_in);
        check("cal early", 0, n_cal);
        ref_ok <= 1'b1;
        repeat (30) @(posedge ref_clk_in);
        check("cal", 1, n_cal);
        xfer(1'b1, `A_PID1, 4, {8'h01, CHIP, PID[7:0], PID[15:8]});
        xfer(1'b0, `A_CFG0, 1, 32'h24);
        xfer(1'b0, 13'h010, 3, 32'hc3b2a1);
        check("active", 0, act[23:0]);
        xfer(1'b1, 13'h00e, 3, 32'ha10000);
        xfer(1'b0, `A_CFG1, 1, 32'h20);
        xfer(1'b1, 13'h011, 1, 32'h00);
        xfer(1'b0, `A_UPDATE, 1, 32'h01);
        check("active", 32'hc3b2a1, act[23:0]);
        xfer(1'b1, `A_UPDATE, 3, 32'hb2a100);
        // Lsb-first and four-wire take effect on the very next frame
        xfer(1'b0, `A_CFG0, 1, 32'h7e);
        wr(`H_MODE, 16'h0003);
        xfer(1'b1, 13'h011, 2, 32'hc3b2);
        xfer(1'b0, `A_CFG0, 1, 32'h24);
        wr(`H_MODE, 16'h0000);
        xfer(1'b0, `A_CFG0, 1, 32'ha6);
        check("soft hold", 0, act[23:0]);
        cmd(16'h0010);
        xfer(1'b1, `A_CFG0, 2, 32'h2026);
        xfer(1'b1, 13'h010, 1, 32'h00);
        xfer(1'b0, 13'h010, 1, 32'h55);
        xfer(1'b0, `A_UPDATE, 1, 32'h01);
        check("active", 32'h55, act[7:0]);
        hw_reset_n <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        hw_reset_n <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        check("hw active", 0, act[31:0]);
        xfer(1'b1, `A_CFG1, 2, 32'h0000);
        xfer(1'b1, 13'h010, 1, 32'h00);
        finish_test;
    end
endmodule
